// ---- hdl/i2cmb_cfg.svh ----
// register map, field positions and timing constants of the i2c master buffer block
`ifndef I2CMB_CFG_SVH
`define I2CMB_CFG_SVH

// ==========================================================================
// register offsets (byte addresses, one aligned word each)
`define I2CMB_OFF_DATA   12'h000
`define I2CMB_OFF_ICTL   12'h004
`define I2CMB_OFF_CTRL   12'h008
`define I2CMB_OFF_STAT   12'h00C

// ==========================================================================
// field positions
`define I2CMB_DAT_START  8
`define I2CMB_ICTL_TEN   0
`define I2CMB_ICTL_REN   1
`define I2CMB_CTL_FUNC   0
`define I2CMB_CTL_GOSTA  1
`define I2CMB_CTL_GOSTO  2
`define I2CMB_CTL_GORCV  3
`define I2CMB_CTL_ACK    4
`define I2CMB_ST_TXE     0
`define I2CMB_ST_RXF     1
`define I2CMB_ST_BUSY    2
`define I2CMB_ST_NACK    3
`define I2CMB_ST_PEND    4

// ==========================================================================
// reset values
`define I2CMB_RST_WORD   32'h0000_0000
`define I2CMB_RST_BYTE   8'h00

// ==========================================================================
// timing: one quarter of an scl period
`define I2CMB_QTR_NS     2500
`define I2CMB_CLK_NS     10
`define I2CMB_QTR_CYC    ((`I2CMB_QTR_NS) / (`I2CMB_CLK_NS))

`endif

// ---- hdl/i2cmb_pkg.sv ----
// types shared by the i2c master buffer block
package i2cmb_pkg;

  // ========================================================================
  // engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP
  } i2cmb_state_e;

endpackage : i2cmb_pkg

// ---- hdl/i2cmb_top.sv ----
// i2c master with buffer flags, shared interrupt and open-drain pins
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "i2cmb_cfg.svh"

module i2cmb_top #(
  parameter int QTR_CYC = `I2CMB_QTR_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);
  import i2cmb_pkg::*;
  localparam logic [15:0] QTR_RELOAD = 16'(QTR_CYC - 1);

  // ========================================================================
  // declarations
  i2cmb_state_e state_q;
  logic [1:0]   phase_q, pin_meta_q, pin_sync_q;
  logic [3:0]   bitcnt_q;
  logic [15:0]  qcnt_q;
  logic [7:0]   shreg_q, hold_q, rx_data_q;
  logic         rx_mode_q, nack_q, tx_pend_q, txf_q, rxf_q;
  logic         ten_q, ren_q, func_q, ack_en_q;
  logic         scl_s, sda_s, acc, wr_data, rd_data, wr_ictl, wr_ctrl;
  logic         func_chg, idle, go_start, go_stop, go_recv, load_tx;
  logic         tick, stall, adv, rx_done;

  // ========================================================================
  // address decode
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `I2CMB_OFF_DATA) || (a == `I2CMB_OFF_ICTL) ||
                (a == `I2CMB_OFF_CTRL) || (a == `I2CMB_OFF_STAT);
  endfunction : is_mapped

  // ========================================================================
  // pin synchronisers: scl and sda come from the open bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
    end else begin
      pin_meta_q <= {scl_i, sda_i};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign scl_s = pin_sync_q[1];
  assign sda_s = pin_sync_q[0];

  // ========================================================================
  // apb slave: one wait state, answer registered
  assign acc     = psel && penable && pready;
  assign wr_data = acc && pwrite && (paddr == `I2CMB_OFF_DATA);
  assign rd_data = acc && !pwrite && (paddr == `I2CMB_OFF_DATA);
  assign wr_ictl = acc && pwrite && (paddr == `I2CMB_OFF_ICTL);
  assign wr_ctrl = acc && pwrite && (paddr == `I2CMB_OFF_CTRL);

  // ready, error and read data are all loaded at the end of the first access cycle and seen in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= `I2CMB_RST_WORD;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          `I2CMB_OFF_DATA: prdata <= {24'h00_0000, rx_data_q};
          `I2CMB_OFF_ICTL: prdata <= {30'h0000_0000, ren_q, ten_q};
          `I2CMB_OFF_CTRL: prdata <= {27'h000_0000, ack_en_q, 3'h0, func_q};
          `I2CMB_OFF_STAT: prdata <= {27'h000_0000, tx_pend_q, nack_q,
                                      !idle, rxf_q, txf_q};
          default:         prdata <= `I2CMB_RST_WORD;
        endcase
      end
    end
  end

  // ========================================================================
  // control registers: enables default off, pins start in port function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ten_q    <= 1'h0;
      ren_q    <= 1'h0;
      func_q   <= 1'h0;
      ack_en_q <= 1'h0;
    end else begin
      if (wr_ictl) begin
        ten_q <= pwdata[`I2CMB_ICTL_TEN];
        ren_q <= pwdata[`I2CMB_ICTL_REN];
      end
      if (wr_ctrl) begin
        func_q   <= pwdata[`I2CMB_CTL_FUNC];
        ack_en_q <= pwdata[`I2CMB_CTL_ACK];
      end
    end
  end

  // commands are only taken while idle with the i2c function selected
  assign idle     = (state_q == ST_IDLE);
  assign func_chg = wr_ctrl && (pwdata[`I2CMB_CTL_FUNC] != func_q);
  assign go_start = wr_ctrl && idle && func_q && !func_chg && pwdata[`I2CMB_CTL_GOSTA];
  assign go_stop  = wr_ctrl && idle && func_q && !func_chg && pwdata[`I2CMB_CTL_GOSTO];
  assign go_recv  = wr_ctrl && idle && func_q && !func_chg && pwdata[`I2CMB_CTL_GORCV];
  assign load_tx  = idle && func_q && tx_pend_q && !wr_ctrl;

  // ========================================================================
  // transmit holding byte: start bit zero only clears the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q    <= `I2CMB_RST_BYTE;
      tx_pend_q <= 1'h0;
    end else if (wr_data && pwdata[`I2CMB_DAT_START]) begin
      hold_q    <= pwdata[7:0];
      tx_pend_q <= 1'h1;
    end else if (load_tx) begin
      tx_pend_q <= 1'h0;
    end
  end

  // ========================================================================
  // buffer flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txf_q <= 1'h0;
    end else if (load_tx) begin
      txf_q <= 1'h1;
    end else if (wr_data) begin
      txf_q <= 1'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxf_q     <= 1'h0;
      rx_data_q <= `I2CMB_RST_BYTE;
    end else if (rx_done) begin
      rxf_q     <= 1'h1;
      rx_data_q <= shreg_q;
    end else if (rd_data) begin
      rxf_q     <= 1'h0;
    end
  end

  // ========================================================================
  // shared request: each buffer flag is gated by its own enable here, then or-ed and registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'h0;
    end else begin
      irq <= (txf_q && ten_q) || (rxf_q && ren_q);
    end
  end

  // ========================================================================
  // quarter-period timer; holds while a slave stretches scl low in phase 2 of a byte bit, not in start or stop
  assign tick    = (qcnt_q == 16'h0000);
  assign stall   = (state_q == ST_BIT) && (phase_q == 2'h2) && !scl_s;
  assign adv     = tick && !stall && !idle;
  assign rx_done = adv && (state_q == ST_BIT) && (phase_q == 2'h3) &&
                   (bitcnt_q == 4'h8) && rx_mode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_q <= 16'h0000;
    end else if (idle || func_chg || adv) begin
      qcnt_q <= QTR_RELOAD;
    end else if (!stall) begin
      qcnt_q <= qcnt_q - 16'h0001;
    end
  end

  // ========================================================================
  // bus engine: start, nine-clock byte, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      phase_q   <= 2'h0;
      bitcnt_q  <= 4'h0;
      shreg_q   <= `I2CMB_RST_BYTE;
      rx_mode_q <= 1'h0;
      nack_q    <= 1'h0;
      scl_oe_n  <= 1'h1;
      sda_oe_n  <= 1'h1;
    end else if (func_chg) begin
      state_q  <= ST_IDLE;
      phase_q  <= 2'h0;
      scl_oe_n <= 1'h1;
      sda_oe_n <= 1'h1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          phase_q  <= 2'h0;
          bitcnt_q <= 4'h0;
          sda_oe_n <= 1'h1;                            // scl is low here, or sda already high after a stop or reset: no false stop
          if (go_start) begin
            state_q <= ST_START;
          end else if (go_stop) begin
            state_q <= ST_STOP;
          end else if (go_recv) begin
            state_q   <= ST_BIT;
            rx_mode_q <= 1'h1;
          end else if (load_tx) begin
            state_q   <= ST_BIT;
            rx_mode_q <= 1'h0;
            shreg_q   <= hold_q;
          end
        end
        ST_START: if (adv) begin
          phase_q <= phase_q + 2'h1;
          unique case (phase_q)
            2'h0: begin
              scl_oe_n <= 1'h1;
              sda_oe_n <= 1'h1;
            end
            2'h1: sda_oe_n <= 1'h0;
            2'h2: scl_oe_n <= 1'h0;
            2'h3: state_q <= ST_IDLE;
          endcase
        end
        ST_STOP: if (adv) begin
          phase_q <= phase_q + 2'h1;
          unique case (phase_q)
            2'h0: sda_oe_n <= 1'h0;
            2'h1: scl_oe_n <= 1'h1;
            2'h2: sda_oe_n <= 1'h1;
            2'h3: state_q <= ST_IDLE;
          endcase
        end
        ST_BIT: if (adv) begin
          phase_q <= phase_q + 2'h1;
          unique case (phase_q)
            // a released line reads high through the pull-up
            2'h0: begin
              if (bitcnt_q == 4'h8) begin
                sda_oe_n <= rx_mode_q ? !ack_en_q : 1'h1;
              end else begin
                sda_oe_n <= rx_mode_q ? 1'h1 : shreg_q[7];
              end
            end
            2'h1: scl_oe_n <= 1'h1;
            2'h2: begin
              if (bitcnt_q == 4'h8) begin
                if (!rx_mode_q) nack_q <= sda_s;
              end else begin
                shreg_q <= {shreg_q[6:0], rx_mode_q & sda_s};
              end
            end
            2'h3: begin
              scl_oe_n <= 1'h0;
              if (bitcnt_q == 4'h8) begin
                state_q  <= ST_IDLE;
                bitcnt_q <= 4'h0;
              end else begin
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          endcase
        end
      endcase
    end
  end

  // ========================================================================
  // output levels: open drain, low is the only level ever driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {scl_o, sda_o} <= 2'h0;
    else {scl_o, sda_o} <= 2'h0;
  end

  // ========================================================================
  // checks
  AST_EN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (!ten_q && !ren_q) ##1 (!ten_q && !ren_q) |-> !irq)
    else $error("request raised with both enables off");
  AST_TX_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    load_tx |=> txf_q && (state_q == ST_BIT) && !rx_mode_q)
    else $error("tx-empty not raised on shifter load");
  AST_RX_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (rxf_q && ren_q) |=> irq) else $error("enabled rx-full did not request");
  AST_RX_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done |=> rxf_q && (rx_data_q == $past(shreg_q)))
    else $error("rx-full or data missing after receive");
  AST_TX_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(txf_q) |-> $past(load_tx) && !rx_mode_q)
    else $error("tx-empty set without a send");
  AST_RX_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rxf_q) |-> $past(rx_mode_q) && $past(adv))
    else $error("rx-full set without a receive");
  AST_WR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !load_tx) |=> !txf_q) else $error("data write did not clear tx-empty");
  AST_NO_SEND: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !pwdata[`I2CMB_DAT_START] && !tx_pend_q && idle) |=> idle && !tx_pend_q)
    else $error("send started with start bit clear");
  AST_RD_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_data && !rx_done) |=> !rxf_q) else $error("data read did not clear rx-full");
  AST_OR: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(txf_q && ten_q) || $past(rxf_q && ren_q))
    else $error("request without a gated flag");
  AST_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(func_q) |-> scl_oe_n && sda_oe_n && idle)
    else $error("pins driven across function switch");
  AST_NO_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    !scl_o && !sda_o) else $error("pin driven high");

endmodule : i2cmb_top

// ---- testbench/i2cmb_slave_model.sv ----
// behavioural i2c slave for the master buffer bench
`timescale 1ns/10ps
module i2cmb_slave_model #(
  parameter int STRETCH_NS = 300
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       rd_mode,
  input  wire logic       slow,
  input  wire logic       nak,
  input  wire logic [7:0] tx_byte,
  output logic            sda_pull,
  output logic            scl_hold,
  output logic      [7:0] rx_byte
);
  logic [3:0] idx;
  logic       act;

  // ==========================================================================
  // framing and bit count
  initial begin
    idx      = 4'hF;
    act      = 1'b0;
    scl_hold = 1'b0;
    rx_byte  = 8'h00;
  end

  // start or stop: data moves while the clock is high
  always @(sda) begin
    if (scl === 1'b1) begin
      act = (sda === 1'b0);
      idx = 4'hF;
    end
  end

  // falling clock ends a bit; a slow slave then holds the clock low
  always @(negedge scl) begin
    if (act) begin
      idx = (idx == 4'h8 || idx == 4'hF) ? 4'h0 : idx + 4'h1;
      if (slow) begin
        scl_hold = 1'b1;
        #(STRETCH_NS) scl_hold = 1'b0;
      end
    end
  end

  // write bytes shift in msb first on the rising clock
  always @(posedge scl) begin
    if (act && !rd_mode && idx < 4'h8) begin
      rx_byte = {rx_byte[6:0], sda};
    end
  end

  // open drain: only ever pulls low, data is set up while the clock is low
  assign sda_pull = act && (rd_mode ? (idx < 4'h8 && !tx_byte[3'h7 - idx[2:0]])
                                    : (idx == 4'h8 && !nak));
endmodule : i2cmb_slave_model

// ---- testbench/i2cmb_top_bench.sv ----
// self-checking bench for the i2c master buffer block
`timescale 1ns/10ps
`include "i2cmb_cfg.svh"
module i2cmb_top_bench;
  typedef struct packed {
    logic [1:0] ictl;
    logic       rx;
    logic       slow;
    logic       nak;
    logic [7:0] data;
    logic [3:0] stat;
    logic       irq_mid;
    logic       irq_end;
  } i2cmb_row_s;

  localparam int LIMIT = 20000;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, err_q, irq;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_w, sda_w;
  logic        rd_mode, slow, nak, sda_pull, scl_hold;
  logic [7:0]  tx_byte, rx_byte;
  int          mismatches, compares, cycles;
  i2cmb_row_s  r;
  // enables, rx/slow/nak, byte, status after byte, irq mid-byte and after
  i2cmb_row_s  rows [7] = '{
    {2'h0, 3'h0, 8'hA5, 4'h1, 2'h0},
    {2'h1, 3'h0, 8'h3C, 4'h1, 2'h3},
    {2'h2, 3'h2, 8'h81, 4'h1, 2'h0},
    {2'h2, 3'h4, 8'hC3, 4'h2, 2'h1},
    {2'h1, 3'h6, 8'h5A, 4'h2, 2'h0},
    {2'h3, 3'h4, 8'h7E, 4'h2, 2'h1},
    {2'h3, 3'h1, 8'h96, 4'h9, 2'h3}
  };

  // bus lines: released means pulled up, any party may pull low
  assign scl_w = (scl_oe_n ? 1'b1 : scl_o) & ~scl_hold;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~sda_pull;

  i2cmb_top #(.QTR_CYC(4)) u_dut (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .irq      (irq),
    .scl_i    (scl_w),
    .scl_o    (scl_o),
    .scl_oe_n (scl_oe_n),
    .sda_i    (sda_w),
    .sda_o    (sda_o),
    .sda_oe_n (sda_oe_n)
  );

  i2cmb_slave_model u_slave (
    .scl      (scl_w),
    .sda      (sda_w),
    .rd_mode  (rd_mode),
    .slow     (slow),
    .nak      (nak),
    .tx_byte  (tx_byte),
    .sda_pull (sda_pull),
    .scl_hold (scl_hold),
    .rx_byte  (rx_byte)
  );

  // ==========================================================================
  // clock, watchdog and pin drive check
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    chk({scl_o, sda_o}, 32'h0);
    if (cycles == LIMIT) begin
      mismatches++;
      test_done();
    end
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after an edge, idle cycle after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // poll status until the engine is idle
  task automatic idle();
    do apb(1'b0, `I2CMB_OFF_STAT, 32'h0); while (rd_q[`I2CMB_ST_BUSY] !== 1'b0);
  endtask : idle

  task automatic test_done();
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    rd_mode = 1'b0;
    slow    = 1'b0;
    nak     = 1'b0;
    tx_byte = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk({irq, scl_oe_n, sda_oe_n}, 32'h3);
    apb(1'b0, `I2CMB_OFF_ICTL, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b0, `I2CMB_OFF_STAT, 32'h0);
    chk(rd_q, 32'h0);
    // unmapped write is refused and changes nothing
    apb(1'b1, 12'h010, 32'h3);
    chk({err_q, irq}, 32'h2);
    apb(1'b0, `I2CMB_OFF_ICTL, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h1);
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h3);
    idle();
    // one byte per row, then both flags cleared by data accesses
    foreach (rows[i]) begin
      r = rows[i];
      rd_mode <= r.rx;
      slow    <= r.slow;
      nak     <= r.nak;
      tx_byte <= r.data;
      apb(1'b1, `I2CMB_OFF_ICTL, {30'h0, r.ictl});
      if (r.rx) apb(1'b1, `I2CMB_OFF_CTRL, 32'h19);
      else apb(1'b1, `I2CMB_OFF_DATA, {23'h0, 1'b1, r.data});
      repeat (3) @(posedge pclk);
      chk(irq, r.irq_mid);
      idle();
      chk(rd_q[3:0], r.stat);
      chk(irq, r.irq_end);
      if (!r.rx) chk(rx_byte, r.data);
      apb(1'b0, `I2CMB_OFF_DATA, 32'h0);
      if (r.rx) chk(rd_q[7:0], r.data);
      apb(1'b1, `I2CMB_OFF_DATA, 32'hFF);
      apb(1'b0, `I2CMB_OFF_STAT, 32'h0);
      chk(rd_q[2:0], 3'h0);
      chk(irq, 1'b0);
    end
    nak     <= 1'b0;
    rd_mode <= 1'b0;
    slow    <= 1'b0;
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h5);
    idle();
    chk({scl_oe_n, sda_oe_n}, 32'h3);
    // pin function switched off in mid-byte: both pins float, engine stops
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h3);
    idle();
    apb(1'b1, `I2CMB_OFF_DATA, 32'h100);
    repeat (40) @(posedge pclk);
    apb(1'b0, `I2CMB_OFF_STAT, 32'h0);
    chk(rd_q[`I2CMB_ST_BUSY], 1'b1);
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h0);
    @(posedge pclk);
    chk({scl_oe_n, sda_oe_n}, 32'h3);
    apb(1'b0, `I2CMB_OFF_STAT, 32'h0);
    chk(rd_q[`I2CMB_ST_BUSY], 1'b0);
    apb(1'b1, `I2CMB_OFF_CTRL, 32'h1);
    chk({scl_oe_n, sda_oe_n}, 32'h3);
    test_done();
  end
endmodule : i2cmb_top_bench
